// >>> backlight_pkg.sv
package backlight_pkg;

	// Clock and time base
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned CLK_PER_MS = 1000000 / CLK_PERIOD_NS;

	// Protection delays, printed figures in their own units
	localparam int unsigned T_STRIKE_MS = 1600;
	localparam int unsigned T_OPEN_NORM_MS = 10;
	localparam int unsigned T_SHORT_MS = 1;
	localparam int unsigned T_CMP_HIGH_MS = 10;
	localparam int unsigned STRIKE_CYC = T_STRIKE_MS * CLK_PER_MS;
	localparam int unsigned OPEN_NORM_CYC = T_OPEN_NORM_MS * CLK_PER_MS;
	localparam int unsigned SHORT_CYC = T_SHORT_MS * CLK_PER_MS;
	localparam int unsigned CMP_HIGH_CYC = T_CMP_HIGH_MS * CLK_PER_MS;
	localparam int unsigned TIMER_W = 32;

	// Bridge timing
	localparam int unsigned T_DEAD_NS = 200;
	localparam int unsigned DEAD_CYC = (T_DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Shortest lag is 1/8 period, so diagonal overlap tops out at 87.5 %
	localparam int unsigned OVL_LAG_SHIFT = 3;
	localparam int unsigned PERIOD_W = 16;

	// Pulse counter limits
	localparam logic [5:0] OVP_PULSES = 6'h20;
	localparam logic [3:0] HFB_PULSES = 4'h8;

	// Positions of the comparator inputs in the synchronised bundle
	localparam int unsigned IN_SUPPLY = 0;
	localparam int unsigned IN_CHIP_ON = 1;
	localparam int unsigned IN_OVER_TEMP = 2;
	localparam int unsigned IN_SW_HIGH = 3;
	localparam int unsigned IN_SW_LOW = 4;
	localparam int unsigned IN_BR_HIGH = 5;
	localparam int unsigned IN_BR_LOW = 6;
	localparam int unsigned IN_DIM_BELOW = 7;
	localparam int unsigned IN_VMAX_1V8 = 8;
	localparam int unsigned IN_VMAX_2V = 9;
	localparam int unsigned IN_VMAX_2V2 = 10;
	localparam int unsigned IN_VMAX_3V = 11;
	localparam int unsigned IN_VMIN_0V3 = 12;
	localparam int unsigned IN_IMIN_1V = 13;
	localparam int unsigned IN_IMIN_0V5 = 14;
	localparam int unsigned IN_IMAX_3V5 = 15;
	localparam int unsigned IN_COMP_3V = 16;
	localparam int unsigned IN_COMP_RAMP = 17;
	localparam int unsigned IN_W = 18;

	typedef enum logic {
		RAMP_CHARGE = 1'b0,
		RAMP_DISCHARGE = 1'b1
	} ramp_t;

	typedef enum logic [1:0] {
		MODE_IDLE = 2'b00,
		MODE_STRIKE = 2'b01,
		MODE_NORMAL = 2'b10
	} mode_t;

	typedef enum logic [3:0] {
		FLT_NONE = 4'h0,
		FLT_ARC = 4'h1,
		FLT_THERMAL = 4'h2,
		FLT_OPEN_STRIKE = 4'h3,
		FLT_OPEN_NORMAL = 4'h4,
		FLT_SHORT = 4'h5,
		FLT_CMP_HIGH = 4'h6,
		FLT_OVER_VOLT = 4'h7,
		FLT_HIGH_FB = 4'h8
	} fault_t;

	// Values after reset
	localparam mode_t MODE_RST = MODE_IDLE;
	localparam ramp_t RAMP_RST = RAMP_CHARGE;
	localparam fault_t FAULT_RST = FLT_NONE;

endpackage : backlight_pkg

// >>> leg_if.sv
`timescale 1ns/1ps
interface leg_if;
	logic req;
	logic en;
	logic hi_on;
	logic lo_on;
	modport ctrl (output req, output en, input hi_on, input lo_on);
	modport leg (input req, input en, output hi_on, output lo_on);
endinterface : leg_if

// >>> sync3.sv
`timescale 1ns/1ps
module sync3 import backlight_pkg::*; #(
	parameter int unsigned W = 1
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A bit moves only once the second and third stage agree
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= (s2_q & ~(s2_q ^ s3_q)) | (q & (s2_q ^ s3_q));
		end
	end
endmodule : sync3

// >>> bridge_leg.sv
`timescale 1ns/1ps
module bridge_leg import backlight_pkg::*; #(
	parameter int unsigned DEAD = DEAD_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	leg_if.leg lg
);
	localparam int unsigned DW = $clog2(DEAD + 1);
	logic [DW-1:0] dead_q;
	logic [DW-1:0] off_cnt_q;
	logic want_hi;
	logic want_lo;

	assign want_hi = lg.en & lg.req;
	assign want_lo = lg.en & ~lg.req;

	// Turn-off is immediate; turn-on waits out the dead interval
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			lg.hi_on <= 1'b0;
			lg.lo_on <= 1'b0;
			dead_q <= '0;
		end else if (lg.hi_on && !want_hi) begin
			lg.hi_on <= 1'b0;
			dead_q <= DW'(DEAD);
		end else if (lg.lo_on && !want_lo) begin
			lg.lo_on <= 1'b0;
			dead_q <= DW'(DEAD);
		end else if (dead_q != '0) begin
			dead_q <= dead_q - 1'b1;
		end else if (want_hi && !lg.lo_on) begin
			lg.hi_on <= 1'b1;
		end else if (want_lo && !lg.hi_on) begin
			lg.lo_on <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			off_cnt_q <= DW'(DEAD);
		end else if (lg.hi_on || lg.lo_on) begin
			off_cnt_q <= '0;
		end else if (off_cnt_q != DW'(DEAD)) begin
			off_cnt_q <= off_cnt_q + 1'b1;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	no_shoot_a: assert property (!(lg.hi_on && lg.lo_on))
		else $error("both switches of one leg on");
	dead_gap_a: assert property (($rose(lg.hi_on) || $rose(lg.lo_on)) |->
		$past(off_cnt_q) == DW'(DEAD))
		else $error("leg switched on before the dead interval ran out");
endmodule : bridge_leg

// >>> backlight_fault_supervisor.sv
`timescale 1ns/1ps
module backlight_fault_supervisor import backlight_pkg::*; #(
	parameter int unsigned STRIKE_LIMIT = STRIKE_CYC,
	parameter int unsigned OPEN_LIMIT = OPEN_NORM_CYC,
	parameter int unsigned SHORT_LIMIT = SHORT_CYC,
	parameter int unsigned CMP_LIMIT = CMP_HIGH_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic supply_ok,
	input wire logic chip_on_input,
	input wire logic over_temperature_fault,
	input wire logic switching_ramp_at_high,
	input wire logic switching_ramp_at_low,
	input wire logic burst_ramp_at_high,
	input wire logic burst_ramp_at_low,
	input wire logic dim_level_below_ramp,
	input wire logic vsense_max_above_1v8,
	input wire logic vsense_max_above_2v,
	input wire logic vsense_max_above_2v2,
	input wire logic vsense_max_above_3v,
	input wire logic vsense_min_below_0v3,
	input wire logic isense_min_below_1v,
	input wire logic isense_min_below_0v5,
	input wire logic isense_max_above_3v5,
	input wire logic compensation_node_above_3v,
	input wire logic compensation_node_above_ramp,
	output logic high_side_left_drive,
	output logic low_side_left_drive,
	output logic high_side_right_drive,
	output logic low_side_right_drive,
	output logic switching_ramp_discharge,
	output logic burst_ramp_discharge,
	output logic strike_mode,
	output logic volt_reg_mode,
	output logic comp_source_cut,
	output logic comp_source_off,
	output logic volt_loop_enable,
	output logic fault_latched,
	output logic [3:0] fault_cause
);
	function automatic ramp_t ramp_next(input ramp_t s, input logic hi, input logic lo);
		case (s)
			RAMP_CHARGE: ramp_next = hi ? RAMP_DISCHARGE : RAMP_CHARGE;
			RAMP_DISCHARGE: ramp_next = lo ? RAMP_CHARGE : RAMP_DISCHARGE;
			default: ramp_next = RAMP_CHARGE;
		endcase
	endfunction : ramp_next

	// Saturating persistence timer; any break in the condition restarts it
	function automatic logic [TIMER_W-1:0] tick(input logic [TIMER_W-1:0] c, input logic cond);
		if (!cond) begin
			tick = '0;
		end else if (c == '1) begin
			tick = c;
		end else begin
			tick = c + 1'b1;
		end
	endfunction : tick

	logic [IN_W-1:0] raw_in;
	logic [IN_W-1:0] in_s;
	logic run;
	mode_t mode_q;
	mode_t mode_d;
	logic striking;
	logic normal;
	logic fault_q;
	logic fault_set;
	fault_t cause_d;
	fault_t cause_q;
	ramp_t sw_q;
	ramp_t burst_q;
	logic cycle_start;
	logic burst_new;
	logic [TIMER_W-1:0] strike_cnt_q;
	logic [TIMER_W-1:0] open_cnt_q;
	logic [TIMER_W-1:0] short_cnt_q;
	logic [TIMER_W-1:0] cmp_cnt_q;
	logic vpulse_prev_q;
	logic ipulse_prev_q;
	logic ovp_edge;
	logic hfb_edge;
	logic [5:0] ovp_cnt_q;
	logic [3:0] hfb_cnt_q;
	logic [PERIOD_W-1:0] cyc_cnt_q;
	logic [PERIOD_W-1:0] period_q;
	logic left_phase_q;
	logic right_phase_q;
	logic right_done_q;
	logic lag_ok;
	logic drive_en_q;
	logic strike_q;
	logic vreg_q;
	logic src_cut_q;
	logic src_off_q;
	logic vloop_q;

	assign raw_in = {compensation_node_above_ramp, compensation_node_above_3v,
		isense_max_above_3v5, isense_min_below_0v5, isense_min_below_1v,
		vsense_min_below_0v3, vsense_max_above_3v, vsense_max_above_2v2,
		vsense_max_above_2v, vsense_max_above_1v8, dim_level_below_ramp,
		burst_ramp_at_low, burst_ramp_at_high, switching_ramp_at_low,
		switching_ramp_at_high, over_temperature_fault, chip_on_input, supply_ok};

	sync3 #(.W(IN_W)) u_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.d(raw_in),
		.q(in_s)
	);

	assign run = in_s[IN_SUPPLY] & in_s[IN_CHIP_ON];
	assign striking = (mode_q == MODE_STRIKE);
	assign normal = (mode_q == MODE_NORMAL);

	always_comb begin
		mode_d = mode_q;
		if (!run) begin
			mode_d = MODE_IDLE;
		end else begin
			case (mode_q)
				MODE_IDLE: mode_d = MODE_STRIKE;
				MODE_STRIKE: mode_d = in_s[IN_IMIN_1V] ? MODE_STRIKE : MODE_NORMAL;
				MODE_NORMAL: mode_d = MODE_NORMAL;
				default: mode_d = MODE_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= MODE_RST;
			strike_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			strike_q <= (mode_d == MODE_STRIKE);
		end
	end

	// Oscillator sequencing, both ramps held charging while stopped
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sw_q <= RAMP_RST;
			burst_q <= RAMP_RST;
		end else if (!run) begin
			sw_q <= RAMP_RST;
			burst_q <= RAMP_RST;
		end else begin
			sw_q <= ramp_next(sw_q, in_s[IN_SW_HIGH], in_s[IN_SW_LOW]);
			burst_q <= ramp_next(burst_q, in_s[IN_BR_HIGH], in_s[IN_BR_LOW]);
		end
	end

	assign cycle_start = run & (sw_q == RAMP_DISCHARGE) & in_s[IN_SW_LOW];
	assign burst_new = run & (burst_q == RAMP_DISCHARGE) & in_s[IN_BR_LOW];

	// Persistence timers, counted in system clocks
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			strike_cnt_q <= '0;
			open_cnt_q <= '0;
			short_cnt_q <= '0;
			cmp_cnt_q <= '0;
		end else begin
			strike_cnt_q <= tick(strike_cnt_q, run & striking & in_s[IN_IMIN_1V]);
			open_cnt_q <= tick(open_cnt_q, run & normal & in_s[IN_IMIN_0V5]);
			short_cnt_q <= tick(short_cnt_q, run & normal & in_s[IN_VMIN_0V3]);
			cmp_cnt_q <= tick(cmp_cnt_q, run & normal & in_s[IN_COMP_3V]);
		end
	end

	assign ovp_edge = in_s[IN_VMAX_2V] & ~vpulse_prev_q;
	assign hfb_edge = in_s[IN_IMAX_3V5] & ~ipulse_prev_q;

	// A pulse landing on the burst edge is kept as the first of the new count
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			vpulse_prev_q <= 1'b0;
			ipulse_prev_q <= 1'b0;
			ovp_cnt_q <= '0;
			hfb_cnt_q <= '0;
		end else begin
			vpulse_prev_q <= in_s[IN_VMAX_2V];
			ipulse_prev_q <= in_s[IN_IMAX_3V5];
			if (!(run && normal)) begin
				ovp_cnt_q <= '0;
				hfb_cnt_q <= '0;
			end else if (burst_new) begin
				ovp_cnt_q <= {5'h00, ovp_edge};
				hfb_cnt_q <= {3'h0, hfb_edge};
			end else begin
				if (ovp_edge && ovp_cnt_q != OVP_PULSES) begin
					ovp_cnt_q <= ovp_cnt_q + 1'b1;
				end
				if (hfb_edge && hfb_cnt_q != HFB_PULSES) begin
					hfb_cnt_q <= hfb_cnt_q + 1'b1;
				end
			end
		end
	end

	// Fault sources in priority order for the cause code
	always_comb begin
		cause_d = FLT_NONE;
		if (in_s[IN_VMAX_3V]) begin
			cause_d = FLT_ARC;
		end else if (in_s[IN_OVER_TEMP]) begin
			cause_d = FLT_THERMAL;
		end else if (striking && strike_cnt_q >= TIMER_W'(STRIKE_LIMIT)) begin
			cause_d = FLT_OPEN_STRIKE;
		end else if (normal && open_cnt_q >= TIMER_W'(OPEN_LIMIT)) begin
			cause_d = FLT_OPEN_NORMAL;
		end else if (normal && short_cnt_q >= TIMER_W'(SHORT_LIMIT)) begin
			cause_d = FLT_SHORT;
		end else if (normal && cmp_cnt_q >= TIMER_W'(CMP_LIMIT)) begin
			cause_d = FLT_CMP_HIGH;
		end else if (normal && ovp_cnt_q == OVP_PULSES) begin
			cause_d = FLT_OVER_VOLT;
		end else if (normal && hfb_cnt_q == HFB_PULSES) begin
			cause_d = FLT_HIGH_FB;
		end
	end

	assign fault_set = run & (cause_d != FLT_NONE);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			fault_q <= 1'b0;
			cause_q <= FAULT_RST;
		end else if (!run) begin
			fault_q <= 1'b0;
			cause_q <= FLT_NONE;
		end else if (fault_set && !fault_q) begin
			fault_q <= 1'b1;
			cause_q <= cause_d;
		end
	end

	// Compensation steering follows the highest voltage sense
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			vreg_q <= 1'b0;
			src_cut_q <= 1'b0;
			src_off_q <= 1'b0;
			vloop_q <= 1'b0;
		end else begin
			vreg_q <= run & ~fault_q & in_s[IN_VMAX_2V];
			src_cut_q <= run & ~fault_q & in_s[IN_VMAX_1V8] & ~in_s[IN_VMAX_2V];
			src_off_q <= run & ~fault_q & in_s[IN_VMAX_2V];
			vloop_q <= run & ~fault_q & in_s[IN_VMAX_2V2];
		end
	end

	// Right leg lags left by the point where the ramp passes compensation
	assign lag_ok = cyc_cnt_q >= (period_q >> OVL_LAG_SHIFT);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cyc_cnt_q <= '0;
			period_q <= '1;
			left_phase_q <= 1'b0;
			right_phase_q <= 1'b0;
			right_done_q <= 1'b0;
		end else if (cycle_start) begin
			cyc_cnt_q <= '0;
			period_q <= cyc_cnt_q + 1'b1;
			left_phase_q <= ~left_phase_q;
			right_done_q <= 1'b0;
			if (!right_done_q) begin
				right_phase_q <= ~right_phase_q;
			end
		end else begin
			if (cyc_cnt_q != '1) begin
				cyc_cnt_q <= cyc_cnt_q + 1'b1;
			end
			if (!right_done_q && lag_ok && !in_s[IN_COMP_RAMP]) begin
				right_phase_q <= ~right_phase_q;
				right_done_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			drive_en_q <= 1'b0;
		end else begin
			drive_en_q <= run & ~fault_q & ~fault_set &
				(striking | (normal & in_s[IN_DIM_BELOW]));
		end
	end

	leg_if left_leg ();
	leg_if right_leg ();
	assign left_leg.req = left_phase_q;
	assign left_leg.en = drive_en_q;
	assign right_leg.req = right_phase_q;
	assign right_leg.en = drive_en_q;

	bridge_leg #(.DEAD(DEAD_CYC)) u_left (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.lg(left_leg.leg)
	);

	bridge_leg #(.DEAD(DEAD_CYC)) u_right (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.lg(right_leg.leg)
	);

	assign high_side_left_drive = left_leg.hi_on;
	assign low_side_left_drive = left_leg.lo_on;
	assign high_side_right_drive = right_leg.hi_on;
	assign low_side_right_drive = right_leg.lo_on;
	assign switching_ramp_discharge = sw_q;
	assign burst_ramp_discharge = burst_q;
	assign strike_mode = strike_q;
	assign volt_reg_mode = vreg_q;
	assign comp_source_cut = src_cut_q;
	assign comp_source_off = src_off_q;
	assign volt_loop_enable = vloop_q;
	assign fault_latched = fault_q;
	assign fault_cause = cause_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence ovp_full_s;
		run && normal && ovp_cnt_q == OVP_PULSES;
	endsequence

	sequence hfb_full_s;
		run && normal && hfb_cnt_q == HFB_PULSES;
	endsequence

	arc_trip_a: assert property (run && in_s[IN_VMAX_3V] |=> fault_q)
		else $error("arc did not latch a shutdown");
	latch_hold_a: assert property (fault_q && run |=> fault_q && !drive_en_q)
		else $error("fault latch released while running");
	latch_clear_a: assert property (!run |=> !fault_q && !drive_en_q)
		else $error("fault or drive survived lockout");
	ovp_trip_a: assert property (ovp_full_s |=> fault_q)
		else $error("over-voltage count did not shut down");
	hfb_trip_a: assert property (hfb_full_s |=> fault_q)
		else $error("high-feedback count did not shut down");
	burst_clear_a: assert property (burst_new |=> ovp_cnt_q <= 6'h01 && hfb_cnt_q <= 4'h1)
		else $error("pulse counters not cleared on burst edge");
	strike_arm_a: assert property (striking |=> ovp_cnt_q == '0 && short_cnt_q == '0
		&& cmp_cnt_q == '0 && hfb_cnt_q == '0)
		else $error("normal-only protection armed in striking");
	burst_gate_a: assert property (normal && !in_s[IN_DIM_BELOW] |=> !drive_en_q)
		else $error("drive allowed with dim level above burst ramp");
	strike_drive_a: assert property (run && striking && !fault_q && !fault_set
		|=> drive_en_q)
		else $error("striking drive was gated");
	short_trip_a: assert property (run && normal && short_cnt_q >= TIMER_W'(SHORT_LIMIT)
		|=> fault_q)
		else $error("short lamp did not shut down");
	strike_time_a: assert property (run && striking
		&& strike_cnt_q >= TIMER_W'(STRIKE_LIMIT) |=> fault_q)
		else $error("striking timeout did not shut down");
endmodule : backlight_fault_supervisor

// >>> lamp_model.sv
`timescale 1ns/1ps
module lamp_model #(
	parameter int unsigned SW_TOP = 30,
	parameter int unsigned BR_TOP = 1000
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic switching_ramp_discharge,
	input wire logic burst_ramp_discharge,
	input wire logic [7:0] comp_level,
	output logic switching_ramp_at_high,
	output logic switching_ramp_at_low,
	output logic burst_ramp_at_high,
	output logic burst_ramp_at_low,
	output logic compensation_node_above_ramp
);
	// Capacitor voltages as counts, one count per clock either way
	logic [15:0] sw_q;
	logic [15:0] br_q;
	// Charging clamps at the top, as a real ramp stalls at the reference
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sw_q <= 16'h0;
		end else if (switching_ramp_discharge && sw_q != 16'h0) begin
			sw_q <= sw_q - 16'h1;
		end else if (!switching_ramp_discharge && sw_q < 16'(SW_TOP)) begin
			sw_q <= sw_q + 16'h1;
		end
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			br_q <= 16'h0;
		end else if (burst_ramp_discharge && br_q != 16'h0) begin
			br_q <= br_q - 16'h1;
		end else if (!burst_ramp_discharge && br_q < 16'(BR_TOP)) begin
			br_q <= br_q + 16'h1;
		end
	end
	assign switching_ramp_at_high = (sw_q >= 16'(SW_TOP));
	assign switching_ramp_at_low = (sw_q == 16'h0);
	assign burst_ramp_at_high = (br_q >= 16'(BR_TOP));
	assign burst_ramp_at_low = (br_q == 16'h0);
	assign compensation_node_above_ramp = ({8'h0, comp_level} > sw_q);
endmodule : lamp_model

// >>> backlight_fault_supervisor_tb.sv
`timescale 1ns/1ps
module backlight_fault_supervisor_tb;
	import backlight_pkg::*;
	localparam int STRIKE_N = 400;
	localparam int OPEN_N = 20;
	localparam int SHORT_N = 10;
	localparam int CMP_N = 20;
	logic sys_clk, rst_b, supply_ok, chip_on_input, over_temperature_fault;
	logic sw_hi, sw_lo, br_hi, br_lo, dim_level_below_ramp, comp_ramp;
	logic v1v8, v2v, v2v2, v3v, vmin_0v3, imin_1v, imin_0v5, imax_3v5, comp_3v;
	logic hl, ll, hr, lr, sw_dis, br_dis, strike_mode, fault_latched;
	logic reg_m, cut, off, loop_en;
	logic [3:0] fault_cause;
	int fails = 0;
	int checked = 0;
	lamp_model partner (.sys_clk(sys_clk), .rst_b(rst_b), .switching_ramp_discharge(sw_dis),
		.burst_ramp_discharge(br_dis), .comp_level(8'h10), .switching_ramp_at_high(sw_hi),
		.switching_ramp_at_low(sw_lo), .burst_ramp_at_high(br_hi), .burst_ramp_at_low(br_lo),
		.compensation_node_above_ramp(comp_ramp));
	backlight_fault_supervisor #(.STRIKE_LIMIT(STRIKE_N), .OPEN_LIMIT(OPEN_N),
		.SHORT_LIMIT(SHORT_N), .CMP_LIMIT(CMP_N)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.supply_ok(supply_ok), .chip_on_input(chip_on_input),
		.over_temperature_fault(over_temperature_fault), .switching_ramp_at_high(sw_hi),
		.switching_ramp_at_low(sw_lo), .burst_ramp_at_high(br_hi), .burst_ramp_at_low(br_lo),
		.dim_level_below_ramp(dim_level_below_ramp), .vsense_max_above_1v8(v1v8),
		.vsense_max_above_2v(v2v), .vsense_max_above_2v2(v2v2), .vsense_max_above_3v(v3v),
		.vsense_min_below_0v3(vmin_0v3), .isense_min_below_1v(imin_1v),
		.isense_min_below_0v5(imin_0v5), .isense_max_above_3v5(imax_3v5),
		.compensation_node_above_3v(comp_3v), .compensation_node_above_ramp(comp_ramp),
		.high_side_left_drive(hl), .low_side_left_drive(ll), .high_side_right_drive(hr),
		.low_side_right_drive(lr), .switching_ramp_discharge(sw_dis),
		.burst_ramp_discharge(br_dis), .strike_mode(strike_mode), .volt_reg_mode(reg_m),
		.comp_source_cut(cut), .comp_source_off(off), .volt_loop_enable(loop_en),
		.fault_latched(fault_latched), .fault_cause(fault_cause));
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	task automatic wait_fault(input int n);
		for (int i = 0; i < n && fault_latched !== 1'b1; i++) @(posedge sys_clk);
		tick(2);
	endtask : wait_fault
	task automatic drive_seen(input int n, output logic seen);
		seen = 1'b0;
		repeat (n) begin
			@(posedge sys_clk);
			if ((hl | ll | hr | lr) === 1'b1) seen = 1'b1;
		end
	endtask : drive_seen
	task automatic restart();
		chip_on_input <= 1'b0;
		tick(10);
		check(fault_latched, 1'b0, "latch after enable low");
		chip_on_input <= 1'b1;
		tick(10);
	endtask : restart
	// Wait out one burst discharge so counting starts in a fresh period
	task automatic align();
		for (int i = 0; i < 5000 && br_dis !== 1'b1; i++) @(posedge sys_clk);
		for (int i = 0; i < 5000 && br_dis !== 1'b0; i++) @(posedge sys_clk);
	endtask : align
	task automatic pulse(input bit hfb, input int n);
		repeat (n) begin
			if (hfb) imax_3v5 <= 1'b1; else v2v <= 1'b1;
			tick(6);
			if (hfb) imax_3v5 <= 1'b0; else v2v <= 1'b0;
			tick(6);
		end
	endtask : pulse
	task automatic set_timed(input int k, input logic v);
		case (k)
			0: imin_0v5 <= v;
			1: vmin_0v3 <= v;
			default: comp_3v <= v;
		endcase
	endtask : set_timed
	task automatic t_startup();
		logic s;
		tick(20);
		check(strike_mode, 1'b0, "idle in lockout");
		supply_ok <= 1'b1;
		tick(10);
		check(strike_mode, 1'b1, "strike after run");
		dim_level_below_ramp <= 1'b0;
		drive_seen(200, s);
		check(s, 1'b1, "strike ignores burst");
		imin_1v <= 1'b0;
		tick(10);
		check(strike_mode, 1'b0, "normal after ignition");
		drive_seen(200, s);
		check(s, 1'b0, "gated while dim high");
		dim_level_below_ramp <= 1'b1;
		drive_seen(200, s);
		check(s, 1'b1, "drive while dim low");
		$display("test startup done");
	endtask : t_startup
	task automatic t_bridge();
		int gap;
		logic lag;
		logic sw;
		{lag, sw} = 2'h0;
		for (int i = 0; i < 300; i++) begin
			@(posedge sys_clk);
			if (hl !== hr) lag = 1'b1;
			if (sw_dis === 1'b1) sw = 1'b1;
		end
		check(lag, 1'b1, "right leg lags left");
		check(sw, 1'b1, "switching ramp discharges");
		for (int i = 0; i < 300 && hl !== 1'b1; i++) @(posedge sys_clk);
		for (int i = 0; i < 300 && hl !== 1'b0; i++) @(posedge sys_clk);
		gap = 0;
		while (gap < 300 && ll !== 1'b1) begin
			@(posedge sys_clk);
			gap++;
		end
		check(gap >= DEAD_CYC && gap < 300, 1'b1, "dead interval");
		$display("test bridge done");
	endtask : t_bridge
	task automatic t_regulation();
		v1v8 <= 1'b1;
		tick(10);
		check({loop_en, reg_m, off, cut}, 4'h1, "band 1v8");
		v2v <= 1'b1;
		tick(10);
		check({loop_en, reg_m, off, cut}, 4'h6, "at 2v");
		v2v2 <= 1'b1;
		tick(10);
		check({loop_en, reg_m, off, cut}, 4'he, "above 2v2");
		{v1v8, v2v, v2v2} <= 3'h0;
		tick(10);
		$display("test regulation done");
	endtask : t_regulation
	task automatic t_instant();
		v3v <= 1'b1;
		wait_fault(10);
		check(fault_cause, FLT_ARC, "arc");
		v3v <= 1'b0;
		tick(20);
		check({fault_latched, hl, ll, hr}, 4'h8, "held latch");
		restart();
		over_temperature_fault <= 1'b1;
		wait_fault(10);
		check(fault_cause, FLT_THERMAL, "thermal");
		over_temperature_fault <= 1'b0;
		supply_ok <= 1'b0;
		tick(10);
		check(fault_latched, 1'b0, "cleared by lockout");
		supply_ok <= 1'b1;
		tick(20);
		$display("test instant done");
	endtask : t_instant
	task automatic t_timed();
		int lim[3] = '{OPEN_N, SHORT_N, CMP_N};
		logic [3:0] cause[3] = '{FLT_OPEN_NORMAL, FLT_SHORT, FLT_CMP_HIGH};
		for (int k = 0; k < 3; k++) begin
			set_timed(k, 1'b1);
			tick(lim[k]);
			check(fault_latched, 1'b0, "early fault");
			wait_fault(20);
			check(fault_cause, cause[k], "timed cause");
			set_timed(k, 1'b0);
			restart();
		end
		$display("test timed done");
	endtask : t_timed
	task automatic t_strike();
		imin_1v <= 1'b1;
		restart();
		{imin_0v5, vmin_0v3, comp_3v} <= 3'h7;
		pulse(1'b1, 8);
		check(fault_latched, 1'b0, "armed in strike");
		{imin_0v5, vmin_0v3, comp_3v} <= 3'h0;
		wait_fault(STRIKE_N);
		check(fault_cause, FLT_OPEN_STRIKE, "strike timeout");
		imin_1v <= 1'b0;
		restart();
		$display("test strike done");
	endtask : t_strike
	task automatic t_pulses();
		align();
		pulse(1'b0, 31);
		check(fault_latched, 1'b0, "31 over-volt pulses");
		align();
		pulse(1'b0, 31);
		check(fault_latched, 1'b0, "count cleared by burst");
		pulse(1'b0, 1);
		wait_fault(10);
		check(fault_cause, FLT_OVER_VOLT, "32 pulses");
		restart();
		align();
		pulse(1'b1, 7);
		check(fault_latched, 1'b0, "7 high-fb pulses");
		pulse(1'b1, 1);
		wait_fault(10);
		check(fault_cause, FLT_HIGH_FB, "8 pulses");
		restart();
		$display("test pulses done");
	endtask : t_pulses
	task automatic results();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results
	// Both switches of one leg on would short the supply
	always @(posedge sys_clk) begin
		if (rst_b && ((hl && ll) || (hr && lr))) begin
			fails++;
			$display("wrong value at %0t: leg shoot-through", $time);
		end
	end
	initial begin
		// Tests need about 10k cycles; 40k leaves room without a long hang
		#200000;
		fails++;
		results();
	end
	initial begin
		{rst_b, supply_ok, chip_on_input, over_temperature_fault, dim_level_below_ramp} <= 5'h4;
		{v1v8, v2v, v2v2, v3v, vmin_0v3, imin_0v5, imax_3v5, comp_3v} <= 8'h0;
		imin_1v <= 1'b1;
		tick(12);
		rst_b <= 1'b1;
		t_startup();
		t_bridge();
		t_regulation();
		t_instant();
		t_timed();
		t_strike();
		t_pulses();
		results();
	end
endmodule : backlight_fault_supervisor_tb
